// ---- lcm_pkg.sv ----
// constants for the level control and mixer routing block
package lcm_pkg;
   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_LEFT_GAIN  = 6'h00;
   localparam logic [5:0] IDX_RIGHT_GAIN = 6'h01;
   localparam logic [5:0] IDX_MODE       = 6'h02;
   localparam logic [5:0] IDX_ALC_CTL1   = 6'h03;
   localparam logic [5:0] IDX_ALC_CTL2   = 6'h04;
   localparam logic [5:0] IDX_STATUS     = 6'h09;
   ////////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [7:0] LEFT_GAIN_RST  = 8'h22;
   localparam logic [7:0] RIGHT_GAIN_RST = 8'h22;
   localparam logic [7:0] MODE_RST       = 8'h0C;
   localparam logic [7:0] ALC_CTL1_RST   = 8'h2B;
   localparam logic [7:0] ALC_CTL2_RST   = 8'h4B;
   ////////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int COPY_BIT     = 7;
   localparam int MUTE_BIT     = 6;
   localparam int GAIN_W       = 6;
   localparam int L2R_BIT      = 0;
   localparam int R2L_BIT      = 1;
   localparam int EDGE_LSB     = 4;
   localparam int ATIME_LSB    = 0;
   localparam int RTIME_LSB    = 3;
   localparam int LEVEL_CONTROL_ON_BIT   = 7;
   localparam int COMP_LSB     = 5;
   localparam int VFIX_BIT     = 4;
   localparam int LVL_LSB      = 0;
   localparam logic [5:0] GAIN_MAX_CODE = 6'h2E;
   localparam logic [5:0] GAIN_MIN_CODE = 6'h00;
   localparam logic [7:0] KNEE_STEPS    = 8'h08;
   ////////////////////////////////////////////////////////////////////////////////
   // timing
   localparam int CLK_PERIOD_NS   = 8;
   localparam int ATTACK_STEP_NS  = 32000;
   localparam int RELEASE_STEP_NS = 4000000;
   localparam int HOLD_NS         = 90000000;
   localparam int ATTACK_STEP_CYC  = (ATTACK_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RELEASE_STEP_CYC = (RELEASE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CYC         = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : lcm_pkg

// ---- lcm_step_timer.sv ----
// programmable step timer: period is base cycles shifted by a setting
`timescale 1ns/10ps
module lcm_step_timer #(
   parameter int BASE_CYC = 4000,
   parameter int CNT_W    = 27
) (
   input  wire logic       clk_sys_i,
   input  wire logic       sys_rst_i,
   input  wire logic       run_i,
   input  wire logic [2:0] shift_i,
   output logic            tick_o
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic             tick;
   } lcm_tmr_t;

   lcm_tmr_t s_q;
   lcm_tmr_t s_d;
   logic [CNT_W-1:0] last_c;

   assign last_c = (CNT_W'(BASE_CYC) << shift_i) - CNT_W'(1);

   always_comb begin
      s_d      = s_q;
      s_d.tick = 1'b0;
      if (!run_i) begin
         s_d.cnt = '0;
      end else if (s_q.cnt >= last_c) begin
         s_d.cnt  = '0;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + CNT_W'(1);
      end
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick_o = s_q.tick;
endmodule // lcm_step_timer

// ---- lcm_level_mixer.sv ----
// level control gain engine, mixer routing and apb register file
// Summary of operation
// - with compression set off the level control acts as a pure limiter above threshold.
// - the level-control gain moves by single half-decibel steps only.
// - the interval between attack steps scales with the attack time setting.
// - mode bit 0 routes the left input to both outputs, bit 1 the right input.
// - while level control is on its gain comes from the left channel gain setting.
// - gain code zero is 1 dB and each code adds 0.5 dB up to 24 dB at code 46.
// - codes above the top linear code saturate at the maximum gain.
// - under level control the gain fields of writes are ignored and the left gain drives both channels.
// - a left gain write with bit 7 set loads the gain into both channel registers.
// - in the compression region output rises by one third of the input rise.
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/10ps
module lcm_level_mixer #(
   parameter int ATTACK_CYC  = lcm_pkg::ATTACK_STEP_CYC,
   parameter int RELEASE_CYC = lcm_pkg::RELEASE_STEP_CYC,
   parameter int HOLD_CYCLES = lcm_pkg::HOLD_CYC,
   parameter int HOLD_W      = 27,
   parameter int TMR_W       = 27
) (
   input  wire logic        clk_sys_i,
   input  wire logic        sys_rst_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [3:0]  pstrb_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic [6:0]  level_excess_i,
   output logic [5:0]       gain_left_o,
   output logic [5:0]       gain_right_o,
   output logic             mute_left_o,
   output logic             mute_right_o,
   output logic [1:0]       out_left_src_o,
   output logic [1:0]       out_right_src_o,
   output logic [3:0]       threshold_sel_o,
   output logic             fixed_power_o,
   output logic [1:0]       edge_rate_o,
   output logic             alc_active_o,
   output logic             alc_compressing_o,
   output logic             alc_limiting_o
);
   typedef struct packed {
      logic [7:0]        left_reg;
      logic [7:0]        right_reg;
      logic [7:0]        mode_reg;
      logic [7:0]        ctl1_reg;
      logic [7:0]        ctl2_reg;
      logic [5:0]        alc_gain;
      logic [HOLD_W-1:0] hold_cnt;
      logic [31:0]       prdata;
      logic [5:0]        gain_l;
      logic [5:0]        gain_r;
      logic              compressing;
      logic              limiting;
   } lcm_state_t;

   lcm_state_t s_q;
   lcm_state_t s_d;

   ////////////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [5:0] lcm_sat(input logic [5:0] code);
      lcm_sat = (code > lcm_pkg::GAIN_MAX_CODE) ? lcm_pkg::GAIN_MAX_CODE : code;
   endfunction

   function automatic logic [8:0] lcm_reduction(input logic [6:0] excess,
                                                input logic [1:0] comp);
      logic [8:0] knee;
      logic [8:0] ex;
      knee = 9'({comp, 8'h00} >> 8) * 9'(lcm_pkg::KNEE_STEPS);
      ex   = {2'b00, excess};
      if (comp == 2'b00) begin
         lcm_reduction = ex;
      end else if (ex <= knee) begin
         lcm_reduction = 9'((ex * 9'h002) / 9'h003);
      end else begin
         lcm_reduction = 9'((knee * 9'h002) / 9'h003) + (ex - knee);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // decode and derived values
   logic       level_control_on_c;
   logic [1:0] comp_c;
   logic [5:0] preset_c;
   logic [8:0] red_c;
   logic [5:0] target_c;
   logic [5:0] idx_c;
   logic       mapped_c;
   logic       wr_c;
   logic       attack_run_c;
   logic       release_run_c;
   logic       attack_tick;
   logic       release_tick;
   logic [8:0] knee_c;

   assign level_control_on_c = s_q.ctl2_reg[lcm_pkg::LEVEL_CONTROL_ON_BIT];
   assign comp_c   = s_q.ctl2_reg[lcm_pkg::COMP_LSB +: 2];
   assign preset_c = lcm_sat(s_q.left_reg[5:0]);
   assign red_c    = lcm_reduction(level_excess_i, comp_c);
   assign target_c = (red_c >= {3'b000, preset_c}) ? lcm_pkg::GAIN_MIN_CODE
                                                    : 6'(9'(preset_c) - red_c);
   assign knee_c   = 9'(comp_c) * 9'(lcm_pkg::KNEE_STEPS);
   assign idx_c    = paddr_i[7:2];
   assign mapped_c = (paddr_i[1:0] == 2'b00) &&
                     ((idx_c <= lcm_pkg::IDX_ALC_CTL2) || (idx_c == lcm_pkg::IDX_STATUS));
   assign wr_c     = psel_i && penable_i && pwrite_i && mapped_c && pstrb_i[0];

   assign attack_run_c  = level_control_on_c && (s_q.alc_gain > target_c);
   assign release_run_c = level_control_on_c && (s_q.alc_gain < target_c) && (s_q.hold_cnt == '0);

   lcm_step_timer #(
      .BASE_CYC (ATTACK_CYC),
      .CNT_W    (TMR_W)
   ) u_attack_tmr (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .run_i     (attack_run_c),
      .shift_i   (s_q.ctl1_reg[lcm_pkg::ATIME_LSB +: 3]),
      .tick_o    (attack_tick)
   );

   lcm_step_timer #(
      .BASE_CYC (RELEASE_CYC),
      .CNT_W    (TMR_W)
   ) u_release_tmr (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .run_i     (release_run_c),
      .shift_i   (s_q.ctl1_reg[lcm_pkg::RTIME_LSB +: 3]),
      .tick_o    (release_tick)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      s_d = s_q;
      // register writes
      if (wr_c) begin
         case (idx_c)
            lcm_pkg::IDX_LEFT_GAIN: begin
               s_d.left_reg[lcm_pkg::MUTE_BIT] = pwdata_i[lcm_pkg::MUTE_BIT];
               if (!level_control_on_c) begin
                  s_d.left_reg[5:0] = pwdata_i[5:0];
               end
               if (pwdata_i[lcm_pkg::COPY_BIT]) begin
                  s_d.right_reg[5:0] = s_d.left_reg[5:0];
               end
            end
            lcm_pkg::IDX_RIGHT_GAIN: begin
               s_d.right_reg[lcm_pkg::MUTE_BIT] = pwdata_i[lcm_pkg::MUTE_BIT];
               if (!level_control_on_c) begin
                  s_d.right_reg[5:0] = pwdata_i[5:0];
               end
               if (pwdata_i[lcm_pkg::COPY_BIT] && !level_control_on_c) begin
                  s_d.left_reg[5:0] = s_d.right_reg[5:0];
               end
            end
            lcm_pkg::IDX_MODE:     s_d.mode_reg = {2'b00, pwdata_i[5:0]};
            lcm_pkg::IDX_ALC_CTL1: s_d.ctl1_reg = {2'b00, pwdata_i[5:0]};
            lcm_pkg::IDX_ALC_CTL2: s_d.ctl2_reg = pwdata_i[7:0];
            default: ;
         endcase
      end
      // read data captured in the setup phase
      if (psel_i && !penable_i) begin
         s_d.prdata = 32'h0000_0000;
         if (mapped_c && !pwrite_i) begin
            case (idx_c)
               lcm_pkg::IDX_LEFT_GAIN:  s_d.prdata[6:0] = s_q.left_reg[6:0];
               lcm_pkg::IDX_RIGHT_GAIN: s_d.prdata[6:0] = s_q.right_reg[6:0];
               lcm_pkg::IDX_MODE:       s_d.prdata[7:0] = s_q.mode_reg;
               lcm_pkg::IDX_ALC_CTL1:   s_d.prdata[7:0] = s_q.ctl1_reg;
               lcm_pkg::IDX_ALC_CTL2:   s_d.prdata[7:0] = s_q.ctl2_reg;
               lcm_pkg::IDX_STATUS:     s_d.prdata[7:0] = {s_q.limiting, s_q.compressing,
                                                           s_q.alc_gain};
               default:                 s_d.prdata = 32'h0000_0000;
            endcase
         end
      end
      // level-control gain counter
      if (!level_control_on_c) begin
         s_d.alc_gain = preset_c;
         s_d.hold_cnt = '0;
      end else if (s_q.alc_gain > preset_c) begin
         s_d.alc_gain = preset_c;
      end else if (s_q.alc_gain > target_c) begin
         s_d.hold_cnt = HOLD_W'(HOLD_CYCLES);
         if (attack_tick) begin
            s_d.alc_gain = s_q.alc_gain - 6'h01;
         end
      end else if (s_q.alc_gain < target_c) begin
         if (s_q.hold_cnt != '0) begin
            s_d.hold_cnt = s_q.hold_cnt - HOLD_W'(1);
         end else if (release_tick) begin
            s_d.alc_gain = s_q.alc_gain + 6'h01;
         end
      end
      s_d.gain_l      = level_control_on_c ? s_q.alc_gain : lcm_sat(s_q.left_reg[5:0]);
      s_d.gain_r      = level_control_on_c ? s_q.alc_gain : lcm_sat(s_q.right_reg[5:0]);
      s_d.compressing = level_control_on_c && (level_excess_i != 7'h00) && (comp_c != 2'b00) &&
                        ({2'b00, level_excess_i} <= knee_c);
      s_d.limiting    = level_control_on_c && (level_excess_i != 7'h00) && !s_d.compressing;
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_q           <= '0;
         s_q.left_reg  <= lcm_pkg::LEFT_GAIN_RST;
         s_q.right_reg <= lcm_pkg::RIGHT_GAIN_RST;
         s_q.mode_reg  <= lcm_pkg::MODE_RST;
         s_q.ctl1_reg  <= lcm_pkg::ALC_CTL1_RST;
         s_q.ctl2_reg  <= lcm_pkg::ALC_CTL2_RST;
         s_q.alc_gain  <= lcm_pkg::LEFT_GAIN_RST[5:0];
         s_q.gain_l    <= lcm_pkg::LEFT_GAIN_RST[5:0];
         s_q.gain_r    <= lcm_pkg::RIGHT_GAIN_RST[5:0];
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs; routing bits: [0] left input, [1] right input, both set sums
   logic l2r_c;
   logic r2l_c;
   assign l2r_c = s_q.mode_reg[lcm_pkg::L2R_BIT];
   assign r2l_c = s_q.mode_reg[lcm_pkg::R2L_BIT];

   assign out_left_src_o    = {r2l_c, l2r_c | ~r2l_c};
   assign out_right_src_o   = {r2l_c | ~l2r_c, l2r_c};
   assign prdata_o          = s_q.prdata;
   assign pready_o          = 1'b1;
   assign pslverr_o         = psel_i && penable_i && !mapped_c;
   assign gain_left_o       = s_q.gain_l;
   assign gain_right_o      = s_q.gain_r;
   assign mute_left_o       = s_q.left_reg[lcm_pkg::MUTE_BIT];
   assign mute_right_o      = s_q.right_reg[lcm_pkg::MUTE_BIT];
   assign threshold_sel_o   = s_q.ctl2_reg[lcm_pkg::LVL_LSB +: 4];
   assign fixed_power_o     = s_q.ctl2_reg[lcm_pkg::VFIX_BIT];
   assign edge_rate_o       = s_q.mode_reg[lcm_pkg::EDGE_LSB +: 2];
   assign alc_active_o      = level_control_on_c;
   assign alc_compressing_o = s_q.compressing;
   assign alc_limiting_o    = s_q.limiting;
endmodule // lcm_level_mixer

// ---- lcm_chk.sv ----
// port assertions for the level control and mixer block
`timescale 1ns/10ps
module lcm_chk #(
   parameter int ATTACK_CYC = 4
) (
   input wire logic        clk_sys_i,
   input wire logic        sys_rst_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [7:0]  paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0]  pstrb_i,
   input wire logic [6:0]  level_excess_i,
   input wire logic [5:0]  gain_left_o,
   input wire logic [5:0]  gain_right_o,
   input wire logic [1:0]  out_left_src_o,
   input wire logic [1:0]  out_right_src_o,
   input wire logic        alc_active_o,
   input wire logic        alc_compressing_o,
   input wire logic        alc_limiting_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   logic        acc;
   logic        dec;
   logic [5:0]  last_q;
   logic [31:0] gap_q;
   logic        dn_q;
   logic [1:0]  comp_q;
   logic [2:0]  atk_q;
   assign acc = psel_i & penable_i & pwrite_i & pstrb_i[0];
   assign dec = gain_left_o < last_q;
   function automatic logic [5:0] sat(input logic [5:0] v);
      return (v > lcm_pkg::GAIN_MAX_CODE) ? lcm_pkg::GAIN_MAX_CODE : v;
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   // cycles between gain moves, mirrored settings
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         last_q <= 6'h22;
         gap_q  <= 32'h0000_0000;
         dn_q   <= 1'b0;
         comp_q <= 2'h2;
         atk_q  <= 3'h3;
      end else begin
         last_q <= gain_left_o;
         if (gain_left_o != last_q) begin
            gap_q <= 32'h0000_0001;
            dn_q  <= dec;
         end else if (gap_q != 32'hFFFF_FFFF) begin
            gap_q <= gap_q + 32'h0000_0001;
         end
         if (acc && paddr_i == 8'h10) comp_q <= pwdata_i[6:5];
         if (acc && paddr_i == 8'h0C) atk_q <= pwdata_i[2:0];
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   sequence mode_wr;
      acc && paddr_i == 8'h08;
   endsequence
   sequence left_wr;
      acc && paddr_i == 8'h00 && !alc_active_o;
   endsequence
   step_size_a: assert property (
      alc_active_o && gain_left_o != last_q |->
      gain_left_o == last_q + 6'h01 || gain_left_o == last_q - 6'h01) else $error("gain jump");
   attack_rate_a: assert property (
      alc_active_o && dec && dn_q |-> gap_q >= 32'(ATTACK_CYC << atk_q)) else $error("fast step");
   track_left_a: assert property (
      alc_active_o && $past(alc_active_o) && $past(alc_active_o, 2) |->
      gain_right_o == gain_left_o) else $error("right gain differs");
   route_left_a: assert property (
      mode_wr |=> out_left_src_o == ($past(pwdata_i[1]) ? {1'b1, $past(pwdata_i[0])} : 2'b01))
      else $error("left route");
   route_right_a: assert property (
      mode_wr |=> out_right_src_o == ($past(pwdata_i[0]) ? {$past(pwdata_i[1]), 1'b1} : 2'b10))
      else $error("right route");
   gain_map_a: assert property (
      left_wr |=> ##1 gain_left_o == sat($past(pwdata_i[5:0], 2))) else $error("left gain");
   copy_both_a: assert property (
      left_wr ##0 pwdata_i[7] |=> ##1 gain_right_o == sat($past(pwdata_i[5:0], 2)))
      else $error("copy gain");
   limit_only_a: assert property (
      alc_active_o && comp_q == 2'h0 && level_excess_i != 7'h00 |=>
      alc_limiting_o && !alc_compressing_o) else $error("not limiting");
   knee_comp_a: assert property (
      alc_active_o && comp_q != 2'h0 && level_excess_i != 7'h00
      && level_excess_i <= {comp_q, 3'b000} |=> alc_compressing_o && !alc_limiting_o)
      else $error("not compressing");
endmodule // lcm_chk

bind lcm_level_mixer lcm_chk #(.ATTACK_CYC(ATTACK_CYC)) u_lcm_chk (.clk_sys_i, .sys_rst_i,
   .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .level_excess_i,
   .gain_left_o, .gain_right_o, .out_left_src_o, .out_right_src_o, .alc_active_o,
   .alc_compressing_o, .alc_limiting_o);

// ---- lcm_level_mixer_tb.sv ----
// self-checking bench for the level control and mixer block
`timescale 1ns/10ps
module lcm_level_mixer_tb;
   logic        clk_sys_i      = 1'b0;
   logic        sys_rst_i      = 1'b1;
   logic        psel_i         = 1'b0;
   logic        penable_i      = 1'b0;
   logic        pwrite_i       = 1'b0;
   logic [7:0]  paddr_i        = 8'h00;
   logic [31:0] pwdata_i       = 32'h0000_0000;
   logic [3:0]  pstrb_i        = 4'hF;
   logic [6:0]  level_excess_i = 7'h00;
   logic [31:0] prdata_o;
   logic        pready_o;
   logic        pslverr_o;
   logic [5:0]  gain_left_o;
   logic [5:0]  gain_right_o;
   logic [1:0]  out_left_src_o;
   logic [1:0]  out_right_src_o;
   logic        alc_active_o;
   logic        alc_compressing_o;
   logic        alc_limiting_o;
   logic        mute_left_o;
   logic        mute_right_o;
   logic [3:0]  threshold_sel_o;
   logic        fixed_power_o;
   logic [1:0]  edge_rate_o;
   logic        err_q;
   logic [31:0] rd_q;
   int          num_errors = 0;
   int          tests_run  = 0;
   logic [7:0]  rst_val [5] = '{8'h22, 8'h22, 8'h0C, 8'h2B, 8'h4B};
   logic [1:0]  ls_e [4]    = '{2'h1, 2'h1, 2'h2, 2'h3};
   logic [1:0]  rs_e [4]    = '{2'h2, 2'h1, 2'h2, 2'h3};

   always #4 clk_sys_i = ~clk_sys_i;

   lcm_level_mixer #(.ATTACK_CYC(4), .RELEASE_CYC(8), .HOLD_CYCLES(5)) u_lcm_level_mixer (
      .clk_sys_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
      .prdata_o, .pready_o, .pslverr_o, .level_excess_i, .gain_left_o, .gain_right_o,
      .mute_left_o, .mute_right_o, .out_left_src_o, .out_right_src_o,
      .threshold_sel_o, .fixed_power_o, .edge_rate_o, .alc_active_o,
      .alc_compressing_o, .alc_limiting_o);

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      psel_i   <= 1'b1;
      pwrite_i <= w;
      paddr_i  <= a;
      pwdata_i <= d;
      @(posedge clk_sys_i);
      penable_i <= 1'b1;
      do @(posedge clk_sys_i); while (pready_o !== 1'b1);
      rd_q  = prdata_o;
      err_q = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask

   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0000_0000);
      chk(nm, e, rd_q);
   endtask

   task automatic gain_is(input logic [5:0] e);
      for (int i = 0; i < 3000 && gain_left_o !== e; i++) @(posedge clk_sys_i);
      chk("gain_left_o", 32'(e), 32'(gain_left_o));
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   initial begin
      #400000;
      num_errors++;
      test_done();
   end

   initial begin
      repeat (10) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      foreach (rst_val[i]) rd("reset value", 8'(4 * i), 32'(rst_val[i]));
      rd("status", 8'h24, 32'h0000_0022);
      rd("unmapped", 8'h14, 32'h0000_0000);
      chk("pslverr_o", 32'h0000_0001, 32'(err_q));
      chk("threshold_sel_o", 32'h0000_000B, 32'(threshold_sel_o));
      chk("fixed_power_o", 32'h0000_0000, 32'(fixed_power_o));
      chk("mute_left_o", 32'h0000_0000, 32'(mute_left_o));
      chk("mute_right_o", 32'h0000_0000, 32'(mute_right_o));
      xfer(1'b1, 8'h00, 32'h0000_003F);
      gain_is(6'h2E);
      xfer(1'b1, 8'h00, 32'h0000_0000);
      gain_is(6'h00);
      xfer(1'b1, 8'h00, 32'h0000_002D);
      gain_is(6'h2D);
      xfer(1'b1, 8'h00, 32'h0000_0091);
      gain_is(6'h11);
      chk("gain_right_o", 32'h0000_0011, 32'(gain_right_o));
      rd("left gain", 8'h00, 32'h0000_0011);
      // every routing choice, summing included, all with level control off
      for (int m = 0; m < 4; m++) begin
         xfer(1'b1, 8'h08, 32'(m) | 32'(m << 4) | 32'h0000_000C);
         @(posedge clk_sys_i);
         chk("edge_rate_o", 32'(m), 32'(edge_rate_o));
         chk("out_left_src_o", 32'(ls_e[m]), 32'(out_left_src_o));
         chk("out_right_src_o", 32'(rs_e[m]), 32'(out_right_src_o));
      end
      xfer(1'b1, 8'h08, 32'h0000_000D);
      pstrb_i <= 4'hE;
      xfer(1'b1, 8'h08, 32'h0000_000E);
      pstrb_i <= 4'hF;
      rd("masked write", 8'h08, 32'h0000_000D);
      xfer(1'b1, 8'h00, 32'h0000_0014);
      xfer(1'b1, 8'h0C, 32'h0000_0001);
      gain_is(6'h14);
      xfer(1'b1, 8'h10, 32'h0000_0095);
      level_excess_i <= 7'h06;
      gain_is(6'h0E);
      chk("alc_limiting_o", 32'h0000_0001, 32'(alc_limiting_o));
      chk("threshold_sel_o", 32'h0000_0005, 32'(threshold_sel_o));
      chk("fixed_power_o", 32'h0000_0001, 32'(fixed_power_o));
      xfer(1'b1, 8'h04, 32'h0000_00EF);
      xfer(1'b1, 8'h00, 32'h0000_0005);
      rd("status", 8'h24, 32'h0000_008E);
      chk("gain_right_o", 32'h0000_000E, 32'(gain_right_o));
      rd("left gain", 8'h00, 32'h0000_0014);
      rd("right gain", 8'h04, 32'h0000_0051);
      chk("mute_right_o", 32'h0000_0001, 32'(mute_right_o));
      xfer(1'b1, 8'h00, 32'h0000_0080);
      rd("right gain", 8'h04, 32'h0000_0054);
      xfer(1'b1, 8'h08, 32'h0000_000E);
      level_excess_i <= 7'h00;
      gain_is(6'h14);
      repeat (60) @(posedge clk_sys_i);
      chk("held gain", 32'h0000_0014, 32'(gain_left_o));
      xfer(1'b1, 8'h10, 32'h0000_00A0);
      level_excess_i <= 7'h06;
      gain_is(6'h10);
      chk("alc_compressing_o", 32'h0000_0001, 32'(alc_compressing_o));
      level_excess_i <= 7'h0C;
      gain_is(6'h0B);
      chk("alc_limiting_o", 32'h0000_0001, 32'(alc_limiting_o));
      level_excess_i <= 7'h00;
      xfer(1'b1, 8'h10, 32'h0000_0000);
      xfer(1'b1, 8'h00, 32'h0000_0005);
      gain_is(6'h05);
      test_done();
   end
endmodule // lcm_level_mixer_tb
